// ===== hdl/fic_flash_id_secreg.v
`timescale 1ns/1ps
`include "fic_consts.vh"

module fic_flash_id_secreg #(
  parameter [7:0] MFR_ID = 8'h5C,          // arbitrary value
  parameter [7:0] DEV_ID = 8'h21,          // arbitrary value
  parameter [7:0] MEM_TYPE = 8'h33,        // arbitrary value
  parameter [7:0] CAPACITY = 8'h44,        // arbitrary value
  parameter [63:0] UNIQUE_ID = 64'h0123456789ABCDEF, // arbitrary value
  parameter [7:0] PARAM_FILL = 8'hFF,
  parameter [23:0] TSE_CYCLES =
    ((`FIC_TSE_US * 1000) + `FIC_CLK_NS - 1) / `FIC_CLK_NS
) (
  input wire clk_sys,
  input wire rstn,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire [3:0] io_in,
  output reg [3:0] io_out,
  output reg [3:0] io_oe,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam [15:0] TRES1_CYCLES =
    (`FIC_TRES1_NS + `FIC_CLK_NS - 1) / `FIC_CLK_NS;
  localparam [15:0] RELEASE_ID_WAIT_TIME_CYCLES =
    (`FIC_RELEASE_ID_WAIT_TIME_NS + `FIC_CLK_NS - 1) / `FIC_CLK_NS;

  // clocks before output begins for each opcode
  function [7:0] hdr_len;
    input [7:0] op;
    begin
      case (op)
        `FIC_OP_RELEASE: hdr_len = `FIC_HDR_RELEASE;
        `FIC_OP_MFR_DEV: hdr_len = `FIC_HDR_MFR_DEV;
        `FIC_OP_MFR_DUAL: hdr_len = `FIC_HDR_MFR_DUAL;
        `FIC_OP_MFR_QUAD: hdr_len = `FIC_HDR_MFR_QUAD;
        `FIC_OP_UNIQUE: hdr_len = `FIC_HDR_UNIQUE;
        `FIC_OP_STD_ID: hdr_len = `FIC_HDR_STD_ID;
        `FIC_OP_PARAM: hdr_len = `FIC_HDR_PARAM;
        default: hdr_len = 8'hFF;
      endcase
    end
  endfunction

  // lanes per clock, used for output only; input is always taken from lane 0
  function [2:0] lane_w;
    input [7:0] op;
    begin
      case (op)
        `FIC_OP_MFR_DUAL: lane_w = 3'h2;
        `FIC_OP_MFR_QUAD: lane_w = 3'h4;
        default: lane_w = 3'h1;
      endcase
    end
  endfunction

  // table contents not held here; reads as fill value
  function [7:0] param_byte;
    input [7:0] addr;
    begin
      param_byte = (addr == 8'h00) ? PARAM_FILL : PARAM_FILL;
    end
  endfunction

  function [7:0] src_byte;
    input [7:0] op;
    input [7:0] idx;
    input [7:0] base;
    reg [63:0] sh;
    begin
      sh = UNIQUE_ID << {idx[2:0], 3'h0};
      case (op)
        `FIC_OP_RELEASE: src_byte = DEV_ID;
        `FIC_OP_MFR_DEV, `FIC_OP_MFR_DUAL, `FIC_OP_MFR_QUAD:
          src_byte = idx[0] ? DEV_ID : MFR_ID;
        `FIC_OP_UNIQUE: src_byte = sh[63:56];
        `FIC_OP_STD_ID:
          src_byte = (idx % 8'h03 == 8'h00) ? MFR_ID :
                     (idx % 8'h03 == 8'h01) ? MEM_TYPE : CAPACITY;
        `FIC_OP_PARAM: src_byte = param_byte(base + idx);
        default: src_byte = 8'hFF;
      endcase
    end
  endfunction

  // place the next bits of a byte on the lanes
  function [3:0] lanes;
    input [7:0] b;
    input [2:0] bp;
    input [2:0] w;
    reg [7:0] sh;
    begin
      sh = b << bp;
      case (w)
        3'h2: lanes = {2'h0, sh[7:6]};
        3'h4: lanes = sh[7:4];
        default: lanes = {2'h0, sh[7], 1'b0};
      endcase
    end
  endfunction

  function [3:0] lane_en;
    input [2:0] w;
    begin
      case (w)
        3'h2: lane_en = 4'h3;
        3'h4: lane_en = 4'hF;
        default: lane_en = 4'h2;
      endcase
    end
  endfunction

  // pin synchronisers; only stage 2 and later are read
  reg cs_s1_reg, cs_s2_reg, cs_s3_reg;
  reg sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  reg [3:0] io_s1_reg, io_s2_reg;

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      io_s1_reg <= 4'h0;
      io_s2_reg <= 4'h0;
    end
    else
    begin
      cs_s1_reg <= spi_cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      sclk_s1_reg <= spi_sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
    end
  end

  wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg & ~cs_s2_reg;
  wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg & ~cs_s2_reg;
  wire cs_rise = cs_s2_reg & ~cs_s3_reg;

  reg [7:0] clk_cnt_reg, op_sr_reg, cmd_reg, last_cmd_reg;
  reg cmd_ok_reg;
  reg [23:0] addr_reg;
  reg [2:0] bitpos_reg;
  reg [7:0] out_idx_reg;
  reg pdown_reg, wel_reg, busy_reg;
  reg [2:0] secreg_lock_bits;
  reg [15:0] rec_cnt_reg;
  reg [23:0] er_cnt_reg;
  reg [1:0] last_sel_reg;
  reg [7:0] er_count_reg;

  wire [7:0] opcode = {op_sr_reg[6:0], io_s2_reg[0]};
  wire recovering = (rec_cnt_reg != 16'h0000);
  wire [2:0] cur_w = lane_w(cmd_reg);
  wire [3:0] bp_sum = {1'b0, bitpos_reg} + {1'b0, cur_w};
  wire [7:0] cur_byte = src_byte(cmd_reg, out_idx_reg, addr_reg[7:0]);
  wire [3:0] sel = addr_reg[15:12];
  wire sel_ok = (sel == 4'h1) || (sel == 4'h2) || (sel == 4'h3);
  wire [1:0] sel_idx = sel[1:0] - 2'h1;
  wire erase_go = cs_rise && cmd_ok_reg &&
                  (cmd_reg == `FIC_OP_SEC_ERASE) &&
                  (clk_cnt_reg == `FIC_HDR_ERASE) &&
                  wel_reg &&
                  (addr_reg[23:16] == 8'h00) &&
                  (addr_reg[11:8] == 4'h0) && sel_ok &&
                  !secreg_lock_bits[sel_idx];
  wire erase_done = busy_reg && (er_cnt_reg == 24'h000001);

  // axi decode of control writes
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg aw_have_reg, w_have_reg;
  wire wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire ctrl_wr = wr_fire && (aw_addr_reg == `FIC_REG_CTRL) && w_strb_reg[0];
  wire set_wel = ctrl_wr && w_data_reg[`FIC_CTRL_SET_WEL];
  wire clr_wel = ctrl_wr && w_data_reg[`FIC_CTRL_CLR_WEL];
  wire go_pdown = ctrl_wr && w_data_reg[`FIC_CTRL_PDOWN];
  wire [2:0] lock_set = ctrl_wr ?
    w_data_reg[`FIC_CTRL_LOCK_LO +: 3] : 3'h0;

  // serial engine
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_cnt_reg <= `FIC_RST_BYTE;
      op_sr_reg <= `FIC_RST_BYTE;
      cmd_reg <= `FIC_RST_BYTE;
      last_cmd_reg <= `FIC_RST_BYTE;
      cmd_ok_reg <= 1'b0;
      addr_reg <= 24'h000000;
      bitpos_reg <= 3'h0;
      out_idx_reg <= `FIC_RST_BYTE;
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end
    else if (cs_s2_reg)
    begin
      clk_cnt_reg <= `FIC_RST_BYTE;
      cmd_ok_reg <= 1'b0;
      bitpos_reg <= 3'h0;
      out_idx_reg <= `FIC_RST_BYTE;
      io_oe <= 4'h0;
    end
    else
    begin
      if (sclk_rise)
      begin
        if (clk_cnt_reg != 8'hFF)
          clk_cnt_reg <= clk_cnt_reg + 8'h01;
        if (clk_cnt_reg < `FIC_OPC_LAST)
          op_sr_reg <= opcode;
        else if (clk_cnt_reg == `FIC_OPC_LAST)
        begin
          cmd_reg <= opcode;
          last_cmd_reg <= opcode;
          // busy or waking: nothing answers
          cmd_ok_reg <= !busy_reg && !recovering &&
            (!pdown_reg || opcode == `FIC_OP_RELEASE);
        end
        else if (clk_cnt_reg < `FIC_HDR_ERASE)
          addr_reg <= {addr_reg[22:0], io_s2_reg[0]};
      end
      if (sclk_fall && cmd_ok_reg &&
          clk_cnt_reg >= hdr_len(cmd_reg))
      begin
        io_out <= lanes(cur_byte, bitpos_reg, cur_w);
        io_oe <= lane_en(cur_w);
        if (bp_sum[3])
        begin
          bitpos_reg <= 3'h0;
          out_idx_reg <= out_idx_reg + 8'h01;
        end
        else
          bitpos_reg <= bp_sum[2:0];
      end
    end
  end

  // device state: power-down, latch, busy, locks
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pdown_reg <= 1'b0;
      wel_reg <= 1'b0;
      busy_reg <= 1'b0;
      secreg_lock_bits <= `FIC_RST_LOCK;
      rec_cnt_reg <= 16'h0000;
      er_cnt_reg <= 24'h000000;
      last_sel_reg <= 2'h0;
      er_count_reg <= `FIC_RST_BYTE;
    end
    else
    begin
      secreg_lock_bits <= secreg_lock_bits | lock_set;
      if (go_pdown && !busy_reg)
        pdown_reg <= 1'b1;
      else if (rec_cnt_reg == 16'h0001)
        pdown_reg <= 1'b0;
      if (cs_rise && cmd_ok_reg && pdown_reg &&
          cmd_reg == `FIC_OP_RELEASE && clk_cnt_reg >= `FIC_OPC_LEN)
        rec_cnt_reg <= (clk_cnt_reg == `FIC_OPC_LEN) ?
          TRES1_CYCLES : RELEASE_ID_WAIT_TIME_CYCLES;
      else if (recovering)
        rec_cnt_reg <= rec_cnt_reg - 16'h0001;
      // a set in the cycle the erase ends wins over the clear
      if (set_wel)
        wel_reg <= 1'b1;
      else if (clr_wel || erase_done)
        wel_reg <= 1'b0;
      if (erase_go)
      begin
        busy_reg <= 1'b1;
        er_cnt_reg <= TSE_CYCLES;
        last_sel_reg <= sel[1:0];
      end
      else if (busy_reg)
      begin
        er_cnt_reg <= er_cnt_reg - 24'h000001;
        if (erase_done)
        begin
          busy_reg <= 1'b0;
          er_count_reg <= er_count_reg + 8'h01;
        end
      end
    end
  end

  // axi4-lite slave, one write and one read at a time
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FIC_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg <= s_axi_awaddr[3:0];
        aw_have_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg == `FIC_REG_CTRL) ?
          `FIC_RESP_OKAY : `FIC_RESP_SLVERR;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // upper address bits are not decoded; registers alias every 16 bytes
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FIC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FIC_RESP_OKAY;
      case (s_axi_araddr[3:0])
        `FIC_REG_CTRL: s_axi_rdata <= 32'h00000000;
        `FIC_REG_STATUS: s_axi_rdata <= {24'h000000, ~cs_s2_reg,
          secreg_lock_bits, recovering, pdown_reg, wel_reg,
          busy_reg};
        `FIC_REG_ERASE_INFO: s_axi_rdata <= {16'h0000, er_count_reg,
          6'h00, last_sel_reg};
        `FIC_REG_LAST_CMD: s_axi_rdata <= {24'h000000, last_cmd_reg};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `FIC_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // fic_flash_id_secreg

// ===== hdl/fic_consts.vh
`ifndef FIC_CONSTS_VH
`define FIC_CONSTS_VH

// opcodes
`define FIC_OP_RELEASE 8'hAB
`define FIC_OP_MFR_DEV 8'h90
`define FIC_OP_MFR_DUAL 8'h92
`define FIC_OP_MFR_QUAD 8'h94
`define FIC_OP_UNIQUE 8'h4B
`define FIC_OP_STD_ID 8'h9F
`define FIC_OP_PARAM 8'h5A
`define FIC_OP_SEC_ERASE 8'h44

// clocks before the first output falling edge
`define FIC_HDR_RELEASE 8'h20
`define FIC_HDR_MFR_DEV 8'h20
`define FIC_HDR_MFR_DUAL 8'h18
`define FIC_HDR_MFR_QUAD 8'h14
`define FIC_HDR_UNIQUE 8'h28
`define FIC_HDR_STD_ID 8'h08
`define FIC_HDR_PARAM 8'h28
`define FIC_HDR_ERASE 8'h20
`define FIC_OPC_LAST 8'h07
`define FIC_OPC_LEN 8'h08

// timing
`define FIC_CLK_NS 8
`define FIC_TRES1_NS 3000
`define FIC_RELEASE_ID_WAIT_TIME_NS 5000
`define FIC_TSE_US 1000

// register offsets
`define FIC_REG_CTRL 4'h0
`define FIC_REG_STATUS 4'h4
`define FIC_REG_ERASE_INFO 4'h8
`define FIC_REG_LAST_CMD 4'hC

// control bits
`define FIC_CTRL_SET_WEL 0
`define FIC_CTRL_CLR_WEL 1
`define FIC_CTRL_PDOWN 2
`define FIC_CTRL_LOCK_LO 4

// reset values
`define FIC_RST_BYTE 8'h00
`define FIC_RST_LOCK 3'h0

// responses
`define FIC_RESP_OKAY 2'h0
`define FIC_RESP_SLVERR 2'h2

`endif

// ===== tb/fic_flash_id_secreg_properties.sv
`timescale 1ns/1ps
module fic_flash_id_secreg_properties (
  input wire clk_sys,
  input wire rstn,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire [3:0] io_in,
  input wire [3:0] io_out,
  input wire [3:0] io_oe,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar = s_axi_arvalid && s_axi_arready;
  chk_oe_idle: assert property (spi_cs_n [*5] |-> io_oe == 4'h0)
    else $error("lanes driven while deselected");
  chk_oe_width: assert property (io_oe == 4'h0 || io_oe == 4'h2 ||
    io_oe == 4'h3 || io_oe == 4'hF)
    else $error("illegal lane enable pattern");
  // outputs may only move after a falling serial clock
  chk_out_hold: assert property ((spi_sclk && !spi_cs_n) [*4] |->
    $stable(io_out) && $stable(io_oe))
    else $error("output moved while serial clock high");
  chk_b_lat: assert property (aw_w |=> (!s_axi_awready && !s_axi_bvalid)
    ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  chk_wr_err: assert property (aw_w && s_axi_awaddr[3:0] != 4'h0 |->
    ##2 s_axi_bresp == 2'h2)
    else $error("write to read-only place accepted");
  chk_r_lat: assert property (ar |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed");
  chk_rd_err: assert property (ar && s_axi_araddr[1:0] != 2'h0 |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  cover property (io_oe == 4'hF);
  cover property (io_oe == 4'h3);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // fic_flash_id_secreg_properties

// ===== tb/fic_host_model.sv
`timescale 1ns/1ps
module fic_host_model (
  input wire clk_sys,
  input wire [3:0] io_out,
  input wire [3:0] io_oe,
  output reg spi_cs_n,
  output reg spi_sclk,
  output wire [3:0] io_in
);
  reg drv = 1'b0;
  reg bit0 = 1'b0;
  reg tog = 1'b0;
  reg [63:0] rx;
  reg [3:0] oe_seen;
  // undriven lanes toggle so a stale level never reads back as data
  assign io_in = (io_oe & io_out) | (~io_oe & (drv ? {4{bit0}} : {4{tog}}));
  always @(posedge clk_sys) tog <= ~tog;
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
  end
  task frame(input [63:0] tx, input integer nt, nr, w);
    integer i;
    begin
      rx = 64'h0;
      oe_seen = 4'h0;
      @(posedge clk_sys);
      spi_cs_n <= 1'b0;
      for (i = 0; i < nt + nr; i = i + 1)
      begin
        drv <= i < nt;
        if (i < nt) bit0 <= tx[63 - i];
        repeat (4) @(posedge clk_sys);
        spi_sclk <= 1'b1;
        if (i >= nt) rx = w == 1 ? {rx[62:0], io_out[1]} :
          w == 2 ? {rx[61:0], io_out[1:0]} : {rx[59:0], io_out};
        oe_seen = oe_seen | io_oe;
        repeat (4) @(posedge clk_sys);
        spi_sclk <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      spi_cs_n <= 1'b1;
      drv <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
  endtask
endmodule // fic_host_model

// ===== tb/fic_flash_id_secreg_bench.sv
`timescale 1ns/1ps
`include "fic_consts.vh"
module fic_flash_id_secreg_bench;
  localparam [7:0] MF = 8'h6A; // arbitrary value
  localparam [7:0] DV = 8'h17; // arbitrary value
  localparam [7:0] MT = 8'h2C; // arbitrary value
  localparam [7:0] CP = 8'h39; // arbitrary value
  localparam [63:0] UID = 64'h1E2D3C4B5A697887; // arbitrary value
  localparam [7:0] PF = 8'hC3;
  reg clk_sys, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg s_axi_arvalid, s_axi_rready;
  reg [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, seed, rdv;
  reg [3:0] s_axi_wstrb;
  reg [1:0] rrs, wrs;
  reg [2:0] lk;
  wire spi_cs_n, spi_sclk, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [3:0] io_in, io_out, io_oe;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer n_fail, check_count, k;
  // short erase time keeps the run brief
  fic_flash_id_secreg #(.MFR_ID(MF), .DEV_ID(DV), .MEM_TYPE(MT),
    .CAPACITY(CP), .UNIQUE_ID(UID), .PARAM_FILL(PF), .TSE_CYCLES(24'd1000))
  u_dut (.clk_sys(clk_sys), .rstn(rstn), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  fic_host_model u_host (.clk_sys(clk_sys), .io_out(io_out), .io_oe(io_oe),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .io_in(io_in));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [31:0] st(input b, w, p, r, input [2:0] l);
    st = {25'h0, l, r, p, w, b};
  endfunction
  task cmp_bits(input [63:0] g, e);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task cmp_word(input [31:0] g, e);
    cmp_bits({32'h0, g}, {32'h0, e});
  endtask
  task hang;
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH %0t bus wait ran out", $time);
      complete_run;
    end
  endtask
  task wr(input [31:0] a, d);
    reg got;
    begin
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      got = 1'b0;
      for (k = 0; k < 60 && !got; k = k + 1)
      begin
        @(posedge clk_sys);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        got = s_axi_bvalid;
        wrs = s_axi_bresp;
      end
      s_axi_bready <= 1'b0;
      if (!got) hang;
    end
  endtask
  task rd(input [31:0] a);
    reg got;
    begin
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      got = 1'b0;
      for (k = 0; k < 60 && !got; k = k + 1)
      begin
        @(posedge clk_sys);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        got = s_axi_rvalid;
        rdv = s_axi_rdata;
        rrs = s_axi_rresp;
      end
      s_axi_rready <= 1'b0;
      if (!got) hang;
    end
  endtask
  task sts(input [31:0] e);
    begin
      rd(`FIC_REG_STATUS);
      cmp_word(rdv, e);
    end
  endtask
  task idr(input [63:0] tx, input integer nt, nr, w, input [63:0] e);
    begin
      u_host.frame(tx, nt, nr, w);
      cmp_bits(u_host.rx, e);
      cmp_word(u_host.oe_seen, w == 1 ? 32'h2 : w == 2 ? 32'h3 : 32'hF);
    end
  endtask
  task ers(input [3:0] s, input integer n);
    begin
      seed = xs(seed);
      u_host.frame({8'h44, 8'h00, s, 4'h0, seed[7:0], 32'h0}, n, 0, 1);
    end
  endtask
  task pollb;
    integer n;
    begin
      for (n = 0; n < 600 && rdv[0] !== 1'b0; n = n + 1) rd(`FIC_REG_STATUS);
      if (rdv[0] !== 1'b0) hang;
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata} = 66'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    seed = 32'h9B72;
    {n_fail, check_count, lk} = 0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    idr({8'h9F, 56'h0}, 8, 4, 1, MF >> 4);
    idr({8'h9F, 56'h0}, 8, 48, 1, {MF, MT, CP, MF, MT, CP});
    idr({8'hAB, 56'h0}, 32, 16, 1, {DV, DV});
    idr({8'h90, 56'h0}, 32, 32, 1, {MF, DV, MF, DV});
    idr({8'h92, 12'h0, 4'hF, 40'h0}, 24, 16, 2, {MF, DV, MF, DV});
    idr({8'h94, 10'h0, 2'h3, 44'h0}, 20, 8, 4, {MF, DV, MF, DV});
    idr({8'h4B, 56'h0}, 40, 64, 1, UID);
    seed = xs(seed);
    idr({8'h5A, 16'h0, seed[7:0], 32'h0}, 40, 16, 1, {PF, PF});
    $display("done: identification");
    ers(4'h1, 32);
    sts(st(0, 0, 0, 0, lk));
    wr(`FIC_REG_CTRL, 32'h1);
    ers(4'h1, 32);
    sts(st(1, 1, 0, 0, lk));
    u_host.frame({8'hAB, 56'h0}, 32, 16, 1);
    cmp_word(u_host.oe_seen, 32'h0);
    sts(st(1, 1, 0, 0, lk));
    pollb;
    sts(st(0, 0, 0, 0, lk));
    rd(`FIC_REG_ERASE_INFO);
    cmp_word(rdv, 32'h0101);
    lk = 3'h2;
    wr(`FIC_REG_CTRL, 32'h21);
    ers(4'h2, 32);
    sts(st(0, 1, 0, 0, lk));
    ers(4'h3, 33);
    sts(st(0, 1, 0, 0, lk));
    ers(4'h0, 32);
    sts(st(0, 1, 0, 0, lk));
    ers(4'h3, 32);
    sts(st(1, 1, 0, 0, lk));
    pollb;
    rd(`FIC_REG_ERASE_INFO);
    cmp_word(rdv, 32'h0203);
    $display("done: erase");
    rd(32'h6);
    cmp_word({rrs, rdv[29:0]}, 32'h80000000);
    wr(`FIC_REG_STATUS, 32'h1);
    cmp_word(wrs, 32'h2);
    s_axi_wstrb <= 4'hE;
    wr(`FIC_REG_CTRL, 32'h1);
    s_axi_wstrb <= 4'hF;
    sts(st(0, 0, 0, 0, lk));
    wr(`FIC_REG_CTRL, 32'h1);
    sts(st(0, 1, 0, 0, lk));
    wr(`FIC_REG_CTRL, 32'h2);
    sts(st(0, 0, 0, 0, lk));
    $display("done: bus");
    wr(`FIC_REG_CTRL, 32'h4);
    u_host.frame({8'h9F, 56'h0}, 8, 24, 1);
    cmp_word(u_host.oe_seen, 32'h0);
    rd(`FIC_REG_LAST_CMD);
    cmp_word(rdv, 32'h9F);
    u_host.frame({8'hAB, 56'h0}, 8, 0, 1);
    sts(st(0, 0, 1, 1, lk));
    repeat (400) @(posedge clk_sys);
    sts(st(0, 0, 0, 0, lk));
    wr(`FIC_REG_CTRL, 32'h4);
    idr({8'hAB, 56'h0}, 32, 16, 1, {DV, DV});
    repeat (450) @(posedge clk_sys);
    sts(st(0, 0, 1, 1, lk));
    repeat (250) @(posedge clk_sys);
    sts(st(0, 0, 0, 0, lk));
    $display("done: power down");
    complete_run;
  end
endmodule // fic_flash_id_secreg_bench
bind fic_flash_id_secreg fic_flash_id_secreg_properties u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
  .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
